// ### src/sass_defines.vh
// Constants shared by the serial converter sequencer files.
`ifndef SASS_DEFINES_VH
`define SASS_DEFINES_VH

// ----------------------------------------------------------------------------
// Control byte layout: SEL bits counted in the first three bits after the start bit, CFG bits in all seven that follow it
// ----------------------------------------------------------------------------
`define SASS_SEL_HI      2
`define SASS_SEL_LO      0
`define SASS_CFG_SEL_HI  6
`define SASS_CFG_SEL_LO  4
`define SASS_CFG_UNI     3
`define SASS_CFG_SGL     2
`define SASS_CFG_PD_HI   1
`define SASS_CFG_PD_LO   0

// ----------------------------------------------------------------------------
// Serial clock counts
// ----------------------------------------------------------------------------
`define SASS_TRACK_BIT   4'h5
`define SASS_HOLD_BIT    4'h8
`define SASS_DECISIONS   4'hC
`define SASS_SAR_STEPS   4'hA
`define SASS_CONV_CLKS   4'hF

// ----------------------------------------------------------------------------
// Reset and start values
// ----------------------------------------------------------------------------
`define SASS_DAC_MID     10'h200
`define SASS_DAC_RST     10'h000
`define SASS_PD_RST      2'h3
`define SASS_RES_W       10

`endif

// ### src/sass_buffer.v
// Two-entry result buffer whose outputs come straight from registers.
`timescale 1ns/100ps
module sass_buffer #(
  parameter WIDTH = 10
) (
  input  wire             clk,
  input  wire             sys_rst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);

  reg             tail_valid;
  reg [WIDTH-1:0] tail_data;
  wire            push;
  wire            pop;

  // A word is only refused once both slots hold data.
  assign in_ready = ~tail_valid;
  assign push     = in_valid & ~tail_valid;
  assign pop      = out_valid & out_ready;

  always @(posedge clk) begin
    if (sys_rst) begin
      out_valid  <= 1'b0;
      tail_valid <= 1'b0;
      out_data   <= {WIDTH{1'b0}};
      tail_data  <= {WIDTH{1'b0}};
    end else begin
      case ({push, pop})
        2'b11: begin
          out_data <= in_data;
        end
        2'b10: begin
          if (!out_valid) begin
            out_data  <= in_data;
            out_valid <= 1'b1;
          end else begin
            tail_data  <= in_data;
            tail_valid <= 1'b1;
          end
        end
        2'b01: begin
          if (tail_valid) begin
            out_data   <= tail_data;
            tail_valid <= 1'b0;
          end else begin
            out_valid <= 1'b0;
          end
        end
        default: begin
          out_valid <= out_valid;
        end
      endcase
    end
  end

endmodule // sass_buffer

// ### src/sass_sequencer.v
// Digital sequencer of a 10-bit, 4-channel serially clocked SAR converter.
//
// What this block does
// - A serial input bit is captured on each rising serial clock edge of the control byte; din is ignored during a conversion.
// - While chip select is high the serial input is ignored entirely.
// - Except in shutdown, the serial output and the strobe change only on rising serial clock edges.
// - Serial output and strobe are released to high impedance while chip select is high.
// - The strobe is high for exactly one serial clock period just before the first decision.
// - A low shutdown input puts the block into shutdown.
// - Tracking starts on the falling edge after the fifth control bit.
// - Hold starts on the falling edge after the eighth control bit, so acquisition is three clocks.
// - Single-ended mode routes the channel to the positive input and the return pin to the negative.
// - Pseudo-differential mode only pairs channels zero with one and two with three.
// - At the end of a conversion the hold capacitor goes back to tracking the positive input.
// - A conversion takes 15 serial clock periods.
// - The first one after chip select falls is the start bit unless the result buffer is full; leading zeros do nothing.
// - Ten decisions follow the strobe, most significant first, one per falling edge.
// - Shutdown overrides the power mode and aborts a conversion at once.
`timescale 1ns/100ps
`include "sass_defines.vh"
module sass_sequencer (
  input  wire                    clk,
  input  wire                    sys_rst,
  input  wire                    sclk,
  input  wire                    cs_n,
  input  wire                    din,
  input  wire                    shutdown_n_input,
  input  wire                    cmp_in,
  input  wire                    result_ready,
  output reg                     dout,
  output reg                     dout_oe,
  output reg                     sample_strobe_out,
  output reg                     sample_strobe_oe,
  output reg  [`SASS_RES_W-1:0]  dac_code,
  output reg                     hold_cap_track,
  output reg  [3:0]              pos_ch_sel,
  output reg  [3:0]              neg_ch_sel,
  output reg                     neg_is_com,
  output reg                     bipolar_mode,
  output reg  [1:0]              power_mode,
  output reg                     powered_down,
  output wire                    result_valid,
  output wire [`SASS_RES_W-1:0]  result_data
);

  localparam ST_IDLE  = 2'b00;
  localparam ST_SHIFT = 2'b01;
  localparam ST_CONV  = 2'b10;

  // --------------------------------------------------------------------------
  // Pin synchronisers and serial clock edge detection
  // --------------------------------------------------------------------------
  reg  [4:0] sync1;
  reg  [4:0] sync2;
  reg        sclk_last;
  wire       sclk_s   = sync2[0];
  wire       cs_low   = ~sync2[1];
  wire       din_s    = sync2[2];
  wire       shutdown_n_input_n_s = sync2[3];
  wire       cmp_s    = sync2[4];
  wire       rise     = sclk_s & ~sclk_last;
  wire       fall     = ~sclk_s & sclk_last;

  always @(posedge clk) begin
    if (sys_rst) begin
      sync1     <= 5'h0A;
      sync2     <= 5'h0A;
      sclk_last <= 1'b0;
    end else begin
      sync1     <= {cmp_in, shutdown_n_input, din, cs_n, sclk};
      sync2     <= sync1;
      sclk_last <= sclk_s;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer state
  // --------------------------------------------------------------------------
  reg  [1:0] state;
  reg  [3:0] bit_cnt;
  reg  [3:0] conv_cnt;
  reg  [6:0] cfg;
  reg        decision;
  reg        push;
  wire       buf_ready;
  wire [3:0] next_conv = conv_cnt + 4'h1;
  wire [3:0] sar_idx   = 4'h9 - conv_cnt;
  wire [2:0] sel_now   = cfg[`SASS_SEL_HI+1:`SASS_SEL_LO+1];
  wire [2:0] sel_cfg   = cfg[`SASS_CFG_SEL_HI:`SASS_CFG_SEL_LO];

  // Channel decode; codes outside the table select nothing.
  function [3:0] sass_pos;
    input [2:0] sel;
    begin
      case (sel)
        3'h1:    sass_pos = 4'h1;
        3'h5:    sass_pos = 4'h2;
        3'h2:    sass_pos = 4'h4;
        3'h6:    sass_pos = 4'h8;
        default: sass_pos = 4'h0;
      endcase
    end
  endfunction

  function [3:0] sass_neg;
    input [2:0] sel;
    begin
      case (sel)
        3'h1:    sass_neg = 4'h2;
        3'h5:    sass_neg = 4'h1;
        3'h2:    sass_neg = 4'h8;
        3'h6:    sass_neg = 4'h4;
        default: sass_neg = 4'h0;
      endcase
    end
  endfunction

  always @(posedge clk) begin
    if (sys_rst || !shutdown_n_input_n_s) begin
      // Shutdown drops whatever is under way, even a conversion.
      state          <= ST_IDLE;
      bit_cnt        <= 4'h0;
      conv_cnt       <= 4'h0;
      cfg            <= 7'h00;
      decision       <= 1'b0;
      push           <= 1'b0;
      dac_code       <= `SASS_DAC_RST;
      hold_cap_track <= 1'b0;
      pos_ch_sel     <= 4'h0;
      neg_ch_sel     <= 4'h0;
      neg_is_com     <= 1'b0;
      bipolar_mode   <= 1'b0;
      power_mode     <= `SASS_PD_RST;
      sample_strobe_out <= 1'b0;
      dout           <= 1'b0;
    end else begin
      push <= 1'b0;
      case (state)
        ST_IDLE: begin
          // The start bit is refused while the result buffer is full, so no
          // finished word can ever be dropped.
          if (rise && cs_low && din_s && buf_ready) begin
            state   <= ST_SHIFT;
            bit_cnt <= 4'h1;
          end
        end
        ST_SHIFT: begin
          if (!cs_low) begin
            state          <= ST_IDLE;
            hold_cap_track <= 1'b0;
          end else if (rise) begin
            cfg     <= {cfg[5:0], din_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (fall && bit_cnt == `SASS_TRACK_BIT) begin
            // Positive channel is the same in both modes, so it is known here.
            hold_cap_track <= 1'b1;
            pos_ch_sel     <= sass_pos(sel_now);
          end else if (fall && bit_cnt == `SASS_HOLD_BIT) begin
            hold_cap_track <= 1'b0;
            state          <= ST_CONV;
            conv_cnt       <= 4'h0;
            dac_code       <= `SASS_DAC_MID;
            bipolar_mode   <= ~cfg[`SASS_CFG_UNI];
            power_mode     <= cfg[`SASS_CFG_PD_HI:`SASS_CFG_PD_LO];
            if (cfg[`SASS_CFG_SGL]) begin
              neg_is_com <= 1'b1;
              neg_ch_sel <= 4'h0;
            end else begin
              neg_is_com <= 1'b0;
              neg_ch_sel <= sass_neg(sel_cfg);
            end
          end
        end
        ST_CONV: begin
          if (fall) begin
            conv_cnt <= next_conv;
            if (next_conv <= `SASS_SAR_STEPS) begin
              decision          <= cmp_s;
              dac_code[sar_idx] <= cmp_s;
              if (sar_idx != 4'h0) begin
                dac_code[sar_idx - 4'h1] <= 1'b1;
              end
            end else begin
              decision <= 1'b0;
            end
            if (next_conv == `SASS_CONV_CLKS) begin
              state          <= ST_IDLE;
              hold_cap_track <= 1'b1;
              push           <= 1'b1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase

      // Outputs move on rising edges only, giving the host a full half period.
      if (rise) begin
        sample_strobe_out <= (state == ST_CONV) && (conv_cnt == 4'h0);
        if (state == ST_CONV && conv_cnt != 4'h0 && conv_cnt <= `SASS_DECISIONS) begin
          dout <= decision;
        end else begin
          dout <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin enables and shutdown flag
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      dout_oe          <= 1'b0;
      sample_strobe_oe <= 1'b0;
      powered_down     <= 1'b0;
    end else begin
      dout_oe          <= cs_low;
      sample_strobe_oe <= cs_low;
      powered_down     <= ~shutdown_n_input_n_s;
    end
  end

  // --------------------------------------------------------------------------
  // Result buffer
  // --------------------------------------------------------------------------
  sass_buffer #(
    .WIDTH (`SASS_RES_W)
  ) u_buffer (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (push),
    .in_ready  (buf_ready),
    .in_data   (dac_code),
    .out_valid (result_valid),
    .out_ready (result_ready),
    .out_data  (result_data)
  );

endmodule // sass_sequencer

// ### sim/sass_seq_properties.sv
// Port-level checks for the serial converter sequencer.
`timescale 1ns/100ps
`include "sass_defines.vh"
module sass_seq_properties (
  input wire                   clk,
  input wire                   sys_rst,
  input wire                   sclk,
  input wire                   cs_n,
  input wire                   shutdown_n_input,
  input wire                   result_ready,
  input wire                   dout,
  input wire                   dout_oe,
  input wire                   sample_strobe_out,
  input wire                   sample_strobe_oe,
  input wire [`SASS_RES_W-1:0] dac_code,
  input wire                   hold_cap_track,
  input wire [3:0]             pos_ch_sel,
  input wire [3:0]             neg_ch_sel,
  input wire                   neg_is_com,
  input wire                   powered_down,
  input wire                   result_valid,
  input wire [`SASS_RES_W-1:0] result_data
);
  // ---------------------------------------------------------------------------
  // Link timing, with sclk at eight system clocks per period
  // ---------------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_acq_end;
    $fell(hold_cap_track) && shutdown_n_input;
  endsequence
  sequence s_conv_tail;
    ##119 !hold_cap_track ##1 hold_cap_track;
  endsequence
  a_oe_released: assert property (cs_n [*6] |-> !dout_oe && !sample_strobe_oe)
    else $error("outputs driven while deselected");
  // A shutdown resets the outputs off the sclk grid, so it is left out here.
  a_out_on_rise: assert property (($changed(dout) || $changed(sample_strobe_out))
    && dout_oe && $past(dout_oe) && shutdown_n_input |-> $past(sclk, 2))
    else $error("output changed away from an sclk rise");
  a_strobe_period: assert property ($rose(sample_strobe_out) |->
    sample_strobe_out [*8] ##1 !sample_strobe_out) else $error("strobe width wrong");
  a_acq_window: assert property ($rose(sample_strobe_out) |-> !hold_cap_track
    && $past(hold_cap_track, 8) && dac_code == `SASS_DAC_MID) else $error("bad hold");
  a_conv_len: assert property (@(posedge clk) disable iff (sys_rst || !shutdown_n_input)
    s_acq_end |-> s_conv_tail) else $error("conversion length wrong");
  a_route_pairs: assert property (s_acq_end |-> neg_ch_sel == (neg_is_com ? 4'h0 :
    {pos_ch_sel[2], pos_ch_sel[3], pos_ch_sel[0], pos_ch_sel[1]})) else $error("bad route");
  a_shutdown_n_input_stop: assert property (!shutdown_n_input [*5] |-> powered_down
    && !hold_cap_track && dac_code == `SASS_DAC_RST) else $error("shutdown ignored");
  a_head_stable: assert property (result_valid && !result_ready |=>
    result_valid && $stable(result_data)) else $error("result head lost");
endmodule // sass_seq_properties

// ### sim/sass_host_model.sv
// Behavioural serial master that frames control bytes and collects replies.
`timescale 1ns/100ps
module sass_host_model (
  output reg        sclk,
  output reg        cs_n,
  output reg        din,
  input  wire       dout,
  input  wire       strobe
);
  reg [25:0] got_dout;
  reg [25:0] got_strb;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end
  // Data changes while sclk is low; sclk stands low outside frames.
  task frame(input [7:0] ctl, input integer n, input sel);
    integer k;
    reg [33:0] bits;
    begin
      bits = {2'h0, ctl, 24'h0};
      cs_n = !sel;
      #80;
      for (k = 0; k < n; k = k + 1) begin
        din  = bits[33];
        bits = bits << 1;
        #80 sclk = 1'b1;
        got_dout = {got_dout[24:0], dout};
        got_strb = {got_strb[24:0], strobe};
        #80 sclk = 1'b0;
      end
      #80 cs_n = 1'b1;
      // Chip select stays high a while, so back-to-back frames are seen apart.
      #160;
    end
  endtask
endmodule // sass_host_model

// ### sim/sass_sequencer_test.sv
// Self-checking bench for the serial converter sequencer.
`timescale 1ns/100ps
module sass_sequencer_test;
  reg         clk, sys_rst, shutdown_n_input, result_ready;
  reg         float_bit;
  reg  [9:0]  vin;
  integer     failures, comparisons, i;
  wire        sclk, cs_n, din, dout, dout_oe, sample_strobe_out, sample_strobe_oe;
  wire        hold_cap_track, neg_is_com, bipolar_mode, powered_down, result_valid;
  wire [9:0]  dac_code, result_data;
  wire [3:0]  pos_ch_sel, neg_ch_sel;
  wire [1:0]  power_mode;
  // The comparator keeps a trial bit while the input is not below the code.
  wire        cmp_in   = vin >= dac_code;
  // A released pin shows a toggling level, never its last value.
  wire        dout_pin = dout_oe ? dout : float_bit;
  wire        strb_pin = sample_strobe_oe ? sample_strobe_out : float_bit;
  sass_sequencer dut (.clk, .sys_rst, .sclk, .cs_n, .din, .shutdown_n_input, .cmp_in,
    .result_ready, .dout, .dout_oe, .sample_strobe_out, .sample_strobe_oe, .dac_code,
    .hold_cap_track, .pos_ch_sel, .neg_ch_sel, .neg_is_com, .bipolar_mode, .power_mode,
    .powered_down, .result_valid, .result_data);
  sass_host_model host (.sclk, .cs_n, .din, .dout(dout_pin), .strobe(strb_pin));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) float_bit <= (float_bit !== 1'b1);
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task pop(input [9:0] exp);
    integer k;
    begin
      for (k = 0; k < 50 && result_valid !== 1'b1; k = k + 1) tick(1);
      check(result_valid, 1'b1);
      check(result_data, exp);
      result_ready = 1'b1;
      tick(1);
      result_ready = 1'b0;
    end
  endtask
  task convert(input [2:0] n, input [9:0] v);
    reg [3:0] pos;
    begin
      pos = 4'h1 << n[1:0];
      vin = v;
      host.frame({1'b1, n[0], n[1], !n[1], n[0], !n[2], n[1], n[2]}, 26, 1'b1);
      check(host.got_strb, 26'h0004000);
      check(host.got_dout, {12'h0, v, 4'h0});
      check(pos_ch_sel, pos);
      check(neg_ch_sel, n[2] ? {pos[2], pos[3], pos[0], pos[1]} : 4'h0);
      check({neg_is_com, bipolar_mode, power_mode}, {!n[2], !n[0], n[1], n[2]});
      check(hold_cap_track, 1'b1);
    end
  endtask
  task t_buffer_full;
    begin
      convert(3'h0, 10'h000);
      convert(3'h1, 10'h3FF);
      host.frame(8'hFF, 26, 1'b1);
      check(host.got_strb, 26'h0);
      pop(10'h000);
      pop(10'h3FF);
      check(result_valid, 1'b0);
    end
  endtask
  task t_abort;
    begin
      vin = 10'h155;
      fork
        host.frame(8'h9F, 26, 1'b1);
        begin
          tick(108);
          shutdown_n_input = 1'b0;
          tick(6);
          check({powered_down, hold_cap_track, dac_code}, 12'h800);
          shutdown_n_input = 1'b1;
        end
      join
      tick(4);
      check({powered_down, result_valid}, 2'h0);
    end
  endtask
  initial begin
    {sys_rst, shutdown_n_input, result_ready, vin} = 13'h1800;
    {failures, comparisons} = 0;
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    check({power_mode, dout_oe, result_valid}, 4'hC);
    tick(4);
    t_abort;
    t_buffer_full;
    for (i = 2; i < 8; i = i + 1) begin
      convert(i[2:0], 10'h91 * i[9:0]);
      pop(10'h91 * i[9:0]);
    end
    host.frame(8'hFF, 26, 1'b0);
    check({dout_oe, sample_strobe_oe, hold_cap_track, result_valid}, 4'h2);
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures = failures + 1;
    report_and_stop;
  end
endmodule // sass_sequencer_test
bind sass_sequencer sass_seq_properties chk (.clk, .sys_rst, .sclk, .cs_n, .shutdown_n_input,
  .result_ready, .dout, .dout_oe, .sample_strobe_out, .sample_strobe_oe, .dac_code,
  .hold_cap_track, .pos_ch_sel, .neg_ch_sel, .neg_is_com, .powered_down, .result_valid,
  .result_data);
